// File: src/system_clock_power_watchdog.sv
// power modes, clock selection, dividers, calibration and watchdog
`timescale 1ns/1ps
`default_nettype none
`include "sysres_defines.svh"
module system_clock_power_watchdog #(
  parameter int N_DIV = `N_DIV,
  parameter int WDT_W = `WDT_W
) (
  // clock and power-on reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // raw levels from oscillators, wake and supply monitors
  input wire logic [`N_SYNC-1:0] async_i,
  // power mode requests from the processor
  input wire logic sleep_req_i,
  input wire logic deep_req_i,
  // clock source and main oscillator trim
  input wire sysres_pkg::clk_src_t src_sel_i,
  input wire logic [2:0] osc_step_i,
  // divider settings
  input wire logic [`DIV_WIDE_W-1:0] div_val_i [N_DIV],
  input wire logic [N_DIV-1:0] div_en_i,
  input wire logic [`DIV_W-1:0] frac_int_i,
  input wire logic [`FRAC_W-1:0] frac_fra_i,
  // calibration
  input wire logic cal_start_i,
  input wire logic [7:0] cal_ticks_i,
  // watchdog
  input wire logic wdt_enable_i,
  input wire logic wdt_src_watch_i,
  input wire logic [WDT_W-1:0] wdt_limit_i,
  input wire logic wdt_kick_i,
  input wire logic cause_clear_i,
  // power and mode outputs
  output sysres_pkg::pmode_t mode_o,
  output sysres_pkg::power_ctl_t power_o,
  output logic sys_reset_o,
  output sysres_pkg::reset_cause_t cause_o,
  // clock outputs
  output logic sel_clk_o,
  output sysres_pkg::clk_src_t cur_src_o,
  output logic [5:0] osc_mhz_o,
  output logic [N_DIV-1:0] div_tick_o,
  output logic frac_tick_o,
  // calibration result
  output logic [`CAL_W-1:0] cal_count_o,
  output logic cal_done_o
);
  import sysres_pkg::*;

  if (N_DIV < 1 || N_DIV > 32 || WDT_W < 2 || WDT_W > 32) begin : g_chk
    $error("unsupported divider count or watchdog width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: three stages, change taken when stages 2 and 3 agree
  logic [`N_SYNC-1:0] s1_reg, s2_reg, s3_reg, clean_reg, clean_d_reg;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      clean_reg <= '0;
      clean_d_reg <= '0;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      clean_reg <= (s2_reg & s3_reg) | (clean_reg & (s2_reg | s3_reg));
      clean_d_reg <= clean_reg;
    end
  end
  wire [`N_SYNC-1:0] rise = clean_reg & ~clean_d_reg;
  wire wake_ev = clean_reg[`SY_WAKE];
  wire supply_ok = clean_reg[`SY_SUPPLY];
  wire brownout = clean_reg[`SY_BROWN];

  ////////////////////////////////////////////////////////////////////////////
  // power mode machine
  localparam int WAKE_MAX = `WAKE_CYC;
  pmode_t pm_reg, pm_next;
  logic [10:0] wake_cnt_reg;
  wire wake_done = (wake_cnt_reg == 11'(WAKE_MAX - 1));
  always_comb begin
    pm_next = pm_reg;
    case (pm_reg)
      PM_ACTIVE: begin
        if (supply_ok && deep_req_i) pm_next = PM_DEEP;
        else if (supply_ok && sleep_req_i) pm_next = PM_SLEEP;
      end
      PM_SLEEP: begin
        if (wake_ev) pm_next = PM_ACTIVE;
      end
      PM_DEEP: begin
        if (wake_ev) pm_next = PM_WAKE;
      end
      PM_WAKE: begin
        if (wake_done) pm_next = PM_ACTIVE;
      end
      default: pm_next = PM_ACTIVE;
    endcase
  end
  // clock gates follow the next mode so they line up with the mode output
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pm_reg <= PM_ACTIVE;
      wake_cnt_reg <= '0;
      power_o <= '{cpu_clk_en: 1'b1, hf_clk_en: 1'b1, cpu_power_on: 1'b1};
    end else begin
      pm_reg <= pm_next;
      wake_cnt_reg <= (pm_reg == PM_WAKE) ? wake_cnt_reg + 11'h001 : 11'h000;
      power_o.cpu_clk_en <= (pm_next == PM_ACTIVE);
      power_o.hf_clk_en <= (pm_next == PM_ACTIVE) || (pm_next == PM_SLEEP);
      power_o.cpu_power_on <= (pm_next != PM_DEEP);
    end
  end
  assign mode_o = pm_reg;

  ////////////////////////////////////////////////////////////////////////////
  // glitch-free source switch: old clock drained low, new one joined low
  swstate_t sw_reg, sw_next;
  clk_src_t cur_reg, cur_next;
  wire [3:0] lvl = clean_reg[3:0];
  always_comb begin
    sw_next = sw_reg;
    cur_next = cur_reg;
    case (sw_reg)
      SW_RUN: begin
        if (src_sel_i != cur_reg) sw_next = SW_DRAIN;
      end
      SW_DRAIN: begin
        if (!lvl[cur_reg]) begin
          sw_next = SW_SWAP;
          cur_next = src_sel_i;
        end
      end
      SW_SWAP: begin
        if (!lvl[cur_reg]) sw_next = SW_RUN;
      end
      default: sw_next = SW_RUN;
    endcase
  end
  // output only ever stretches a low phase, never cuts a high one short
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sw_reg <= SW_RUN;
      cur_reg <= SRC_MAIN;
      sel_clk_o <= 1'b0;
    end else begin
      sw_reg <= sw_next;
      cur_reg <= cur_next;
      sel_clk_o <= (sw_next == SW_SWAP) ? 1'b0 : lvl[cur_next];
    end
  end
  assign cur_src_o = cur_reg;

  ////////////////////////////////////////////////////////////////////////////
  // main oscillator trim, clamped to the top step
  wire [2:0] step = (osc_step_i > `OSC_MAX_STEP) ? `OSC_MAX_STEP : osc_step_i;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) osc_mhz_o <= `OSC_BASE_MHZ;
    else osc_mhz_o <= `OSC_BASE_MHZ + 6'(step * `OSC_STEP_MHZ);
  end

  ////////////////////////////////////////////////////////////////////////////
  // integer dividers on the fast clock; divider 0 is the wide one
  wire hf_on = power_o.hf_clk_en;
  for (genvar i = 0; i < N_DIV; i++) begin : g_div
    localparam int W = (i == 0) ? `DIV_WIDE_W : `DIV_W;
    logic [W-1:0] cnt_reg;
    wire [W-1:0] lim = div_val_i[i][W-1:0];
    wire hit = div_en_i[i] && hf_on && (cnt_reg >= lim);
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        cnt_reg <= '0;
        div_tick_o[i] <= 1'b0;
      end else begin
        cnt_reg <= (!div_en_i[i] || hit) ? '0 : (hf_on ? cnt_reg + 1'b1 : cnt_reg);
        div_tick_o[i] <= hit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fractional divider: carry of the fraction lengthens one period by a cycle
  logic [`DIV_W-1:0] fcnt_reg;
  logic [`FRAC_W-1:0] facc_reg;
  logic fextra_reg;
  wire [`FRAC_W:0] fsum = {1'b0, facc_reg} + {1'b0, frac_fra_i};
  wire [`DIV_W:0] flim = {1'b0, frac_int_i} + {{`DIV_W{1'b0}}, fextra_reg};
  wire fhit = hf_on && ({1'b0, fcnt_reg} >= flim);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fcnt_reg <= '0;
      facc_reg <= '0;
      fextra_reg <= 1'b0;
      frac_tick_o <= 1'b0;
    end else begin
      fcnt_reg <= fhit ? '0 : (hf_on ? fcnt_reg + 1'b1 : fcnt_reg);
      if (fhit) begin
        facc_reg <= fsum[`FRAC_W-1:0];
        fextra_reg <= fsum[`FRAC_W];
      end
      frac_tick_o <= fhit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // calibration: main clock cycles across a number of slow oscillator ticks
  logic cal_run_reg;
  logic [7:0] cal_left_reg;
  wire slow_tick = rise[`SY_SLOW];
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cal_run_reg <= 1'b0;
      cal_left_reg <= '0;
      cal_count_o <= '0;
      cal_done_o <= 1'b0;
    end else if (cal_start_i) begin
      cal_run_reg <= 1'b0;
      cal_left_reg <= cal_ticks_i;
      cal_count_o <= '0;
      cal_done_o <= 1'b0;
    end else if (!cal_run_reg && !cal_done_o && slow_tick) begin
      cal_run_reg <= (cal_left_reg != 8'h00); // window opens on a tick edge
      cal_done_o <= (cal_left_reg == 8'h00);
    end else if (cal_run_reg) begin
      cal_count_o <= cal_count_o + 1'b1;
      if (slow_tick) begin
        cal_left_reg <= cal_left_reg - 8'h01;
        cal_run_reg <= (cal_left_reg != 8'h01);
        cal_done_o <= (cal_left_reg == 8'h01);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog on the slow or watch oscillator; clk_i stays up in deep sleep
  logic [WDT_W-1:0] wdt_reg;
  wire wdt_tick = wdt_src_watch_i ? rise[`SY_WATCH] : rise[`SY_SLOW];
  wire wdt_fire = wdt_enable_i && !wdt_kick_i && wdt_tick && (wdt_reg >= wdt_limit_i);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) wdt_reg <= '0;
    else if (wdt_kick_i || !wdt_enable_i || wdt_fire) wdt_reg <= '0;
    else if (wdt_tick) wdt_reg <= wdt_reg + 1'b1;
  end

  // device reset request and sticky cause; power-on or cause_clear_i clears the cause
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sys_reset_o <= 1'b0;
      cause_o <= '0;
    end else begin
      sys_reset_o <= wdt_fire || brownout;
      cause_o.watchdog <= wdt_fire || (cause_o.watchdog && !cause_clear_i);
      cause_o.brownout <= brownout || (cause_o.brownout && !cause_clear_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_enter_wake;
    pm_reg == PM_DEEP && wake_ev;
  endsequence
  // wake phase starts with its counter cleared
  sequence s_wake_out;
    pm_reg == PM_WAKE && wake_cnt_reg == 11'h000;
  endsequence

  property p_mode_step;
    pm_reg == PM_SLEEP |=> pm_reg inside {PM_SLEEP, PM_ACTIVE};
  endproperty
  a_mode_step: assert property (p_mode_step) else $error("sleep left to a wrong mode");
  property p_active_clk;
    pm_reg == PM_ACTIVE |-> power_o.cpu_clk_en && power_o.hf_clk_en && power_o.cpu_power_on;
  endproperty
  a_active_clk: assert property (p_active_clk) else $error("clock gated in full-run");
  property p_sleep_wake;
    pm_reg == PM_SLEEP && wake_ev |=> pm_reg == PM_ACTIVE && power_o.cpu_clk_en;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("light sleep wake late");
  property p_deep_wake;
    s_enter_wake |=> !power_o.hf_clk_en ##0 s_wake_out;
  endproperty
  a_deep_wake: assert property (p_deep_wake) else $error("deep wake time wrong");
  // wake phase outlasts any delay range, so its counter is followed step by step
  property p_wake_hold;
    pm_reg == PM_WAKE && wake_cnt_reg != 11'(WAKE_MAX - 1)
      |=> pm_reg == PM_WAKE && wake_cnt_reg == $past(wake_cnt_reg) + 11'h001;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("deep wake count skipped");
  property p_wake_exit;
    pm_reg == PM_WAKE && wake_cnt_reg == 11'(WAKE_MAX - 1) |=> pm_reg == PM_ACTIVE && power_o.hf_clk_en;
  endproperty
  a_wake_exit: assert property (p_wake_exit) else $error("deep wake not ended on time");
  property p_wake_min;
    s_enter_wake |=> (pm_reg == PM_WAKE)[*8];
  endproperty
  a_wake_min: assert property (p_wake_min) else $error("deep wake too short");
  property p_hold_off;
    pm_reg == PM_ACTIVE && !supply_ok |=> pm_reg == PM_ACTIVE;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("mode entered on low supply");
  property p_brown;
    brownout |=> sys_reset_o && cause_o.brownout;
  endproperty
  a_brown: assert property (p_brown) else $error("brown-out reset missing");
  property p_swap_low;
    sw_reg == SW_SWAP |-> !sel_clk_o;
  endproperty
  a_swap_low: assert property (p_swap_low) else $error("clock not held during swap");
  property p_osc;
    osc_mhz_o >= 6'h18 && osc_mhz_o <= 6'h30 && osc_mhz_o[1:0] == 2'b00;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator trim out of range");
  property p_wdt_fire;
    wdt_enable_i && wdt_tick && !wdt_kick_i && wdt_reg >= wdt_limit_i |=> sys_reset_o && cause_o.watchdog;
  endproperty
  a_wdt_fire: assert property (p_wdt_fire) else $error("watchdog timeout missed");
  property p_kick;
    wdt_kick_i && !brownout |=> wdt_reg == '0 && !sys_reset_o;
  endproperty
  a_kick: assert property (p_kick) else $error("service did not restart count");
  property p_cause_keep;
    cause_o.watchdog && !cause_clear_i |=> cause_o.watchdog;
  endproperty
  a_cause_keep: assert property (p_cause_keep) else $error("reset cause lost");
endmodule
`default_nettype wire

// File: src/sysres_defines.svh
// timing counts, field positions and reset values of the system resources block
`ifndef SYSRES_DEFINES_SVH
`define SYSRES_DEFINES_SVH
`define CLK_MHZ 40
`define WAKE_TIME_NS 35000
`define WAKE_CYC ((`WAKE_TIME_NS * `CLK_MHZ + 999) / 1000)
`define OSC_BASE_MHZ 6'h18
`define OSC_STEP_MHZ 6'h04
`define OSC_MAX_STEP 3'h6
`define N_DIV 11
`define DIV_W 16
`define DIV_WIDE_W 24
`define FRAC_W 5
`define N_SYNC 7
`define SY_MAIN 0
`define SY_SLOW 1
`define SY_WATCH 2
`define SY_EXT 3
`define SY_WAKE 4
`define SY_SUPPLY 5
`define SY_BROWN 6
`define WDT_W 16
`define CAL_W 24
`endif

// File: src/sysres_pkg.sv
// types shared by the system resources block
package sysres_pkg;
  typedef enum logic [1:0] {
    PM_ACTIVE = 2'b00,
    PM_SLEEP = 2'b01,
    PM_DEEP = 2'b10,
    PM_WAKE = 2'b11
  } pmode_t;
  typedef enum logic [1:0] {
    SW_RUN = 2'b00,
    SW_DRAIN = 2'b01,
    SW_SWAP = 2'b10
  } swstate_t;
  typedef enum logic [1:0] {
    SRC_MAIN = 2'b00,
    SRC_SLOW = 2'b01,
    SRC_WATCH = 2'b10,
    SRC_EXT = 2'b11
  } clk_src_t;
  typedef struct packed {
    logic cpu_clk_en;
    logic hf_clk_en;
    logic cpu_power_on;
  } power_ctl_t;
  typedef struct packed {
    logic watchdog;
    logic brownout;
  } reset_cause_t;
endpackage

// File: bench/system_clock_power_watchdog_test.sv
// self-checking bench for the power, clock and watchdog block
`timescale 1ns/1ps
`default_nettype none
`include "sysres_defines.svh"
module system_clock_power_watchdog_test;
  import sysres_pkg::*;
  // clock, reset, counters and oscillator phase
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  int n_fail = 0;
  int checks = 0;
  int k;
  logic [7:0] osc_cnt = 8'h00;
  logic wake = 1'b0;
  logic supply = 1'b0;
  logic brown = 1'b0;
  // design inputs
  logic [`N_SYNC-1:0] async_i;
  logic sleep_req_i = 1'b0;
  logic deep_req_i = 1'b0;
  clk_src_t src_sel_i = SRC_MAIN;
  logic [2:0] osc_step_i = 3'h0;
  logic [`DIV_WIDE_W-1:0] div_val_i [`N_DIV];
  logic [`N_DIV-1:0] div_en_i = '0;
  logic [`DIV_W-1:0] frac_int_i = 16'h0003;
  logic [`FRAC_W-1:0] frac_fra_i = 5'h00;
  logic cal_start_i = 1'b0;
  logic [7:0] cal_ticks_i = 8'h04;
  logic wdt_enable_i = 1'b0;
  logic wdt_src_watch_i = 1'b0;
  logic [`WDT_W-1:0] wdt_limit_i = 16'h0003;
  logic wdt_kick_i = 1'b0;
  logic cause_clear_i = 1'b0;
  // design outputs
  pmode_t mode_o;
  power_ctl_t power_o;
  logic sys_reset_o;
  reset_cause_t cause_o;
  logic sel_clk_o;
  clk_src_t cur_src_o;
  logic [5:0] osc_mhz_o;
  logic [`N_DIV-1:0] div_tick_o;
  logic frac_tick_o;
  logic [`CAL_W-1:0] cal_count_o;
  logic cal_done_o;
  wire [`N_DIV:0] all_ticks;
  ////////////////////////////////////////////////////////////////////////
  // oscillators as levels of periods 4, 8, 16 and 32 cycles; a level that
  // toggles every cycle would never pass the two-stage agreement filter
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    osc_cnt <= osc_cnt + 8'h01;
  end
  assign async_i = {brown, supply, wake, osc_cnt[2], osc_cnt[4], osc_cnt[3], osc_cnt[1]};
  assign all_ticks = {frac_tick_o, div_tick_o};
  system_clock_power_watchdog DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .async_i(async_i),
    .sleep_req_i(sleep_req_i), .deep_req_i(deep_req_i), .src_sel_i(src_sel_i), .osc_step_i(osc_step_i),
    .div_val_i(div_val_i), .div_en_i(div_en_i), .frac_int_i(frac_int_i), .frac_fra_i(frac_fra_i),
    .cal_start_i(cal_start_i), .cal_ticks_i(cal_ticks_i), .wdt_enable_i(wdt_enable_i),
    .wdt_src_watch_i(wdt_src_watch_i), .wdt_limit_i(wdt_limit_i), .wdt_kick_i(wdt_kick_i),
    .cause_clear_i(cause_clear_i), .mode_o(mode_o), .power_o(power_o), .sys_reset_o(sys_reset_o),
    .cause_o(cause_o), .sel_clk_o(sel_clk_o), .cur_src_o(cur_src_o), .osc_mhz_o(osc_mhz_o),
    .div_tick_o(div_tick_o), .frac_tick_o(frac_tick_o), .cal_count_o(cal_count_o), .cal_done_o(cal_done_o));
  ////////////////////////////////////////////////////////////////////////
  // shared helpers
  task end_sim();
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      n_fail++;
    end
  endtask
  task give_up(input string what);
    $display("[ERR] %s expected event seen timeout", what);
    n_fail++;
    end_sim();
  endtask
  // sample just after the edge so its updates have landed
  task step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // cycles from one tick of a divider to the next
  task meas(input int i, output int p);
    for (k = 0; k < 40 && all_ticks[i] !== 1'b1; k++) step(1);
    if (all_ticks[i] !== 1'b1) give_up("tick_start");
    for (p = 1; p < 40; p++) begin
      step(1);
      if (all_ticks[i] === 1'b1) break;
    end
    if (all_ticks[i] !== 1'b1) give_up("tick_next");
  endtask
  // kick once, then time the unserviced timeout and the cause bit
  task dog_fire(input int lo, input int hi);
    @(posedge clk_i);
    wdt_kick_i <= 1'b1;
    @(posedge clk_i);
    wdt_kick_i <= 1'b0;
    #1;
    for (k = 0; k < 300 && sys_reset_o !== 1'b1; k++) step(1);
    if (sys_reset_o !== 1'b1) give_up("dog_reset");
    chk("dog_delay_ok", 1, k >= lo && k <= hi);
    chk("cause_dog", 1, cause_o.watchdog);
    step(1);
    chk("reset_pulse", 0, sys_reset_o);
    step(20);
    chk("cause_kept", 1, cause_o.watchdog);
    @(posedge clk_i);
    cause_clear_i <= 1'b1;
    @(posedge clk_i);
    cause_clear_i <= 1'b0;
    step(1);
    chk("cause_clr", 0, cause_o);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_reset();
    chk("mode", PM_ACTIVE, mode_o);
    chk("power", 3'b111, power_o);
    chk("osc_mhz", 24, osc_mhz_o);
    chk("cur_src", SRC_MAIN, cur_src_o);
  endtask
  task t_osc();
    for (int s = 0; s < 8; s++) begin
      @(posedge clk_i);
      osc_step_i <= 3'(s);
      step(3);
      chk("osc_mhz", 24 + 4 * (s > 6 ? 6 : s), osc_mhz_o);
    end
  endtask
  task t_sleep();
    @(posedge clk_i);
    sleep_req_i <= 1'b1;
    @(posedge clk_i);
    sleep_req_i <= 1'b0;
    step(1);
    chk("sleep_mode", PM_SLEEP, mode_o);
    chk("sleep_power", 3'b011, power_o);
    @(posedge clk_i);
    wake <= 1'b1;
    for (k = 0; k < 8 && mode_o !== PM_ACTIVE; k++) step(1);
    if (mode_o !== PM_ACTIVE) give_up("sleep_exit");
    @(posedge clk_i);
    wake <= 1'b0;
    step(6);
  endtask
  // low supply refuses entry; brown-out resets and is recorded
  task t_supply();
    @(posedge clk_i);
    supply <= 1'b0;
    step(6);
    @(posedge clk_i);
    sleep_req_i <= 1'b1;
    @(posedge clk_i);
    sleep_req_i <= 1'b0;
    step(3);
    chk("refused", PM_ACTIVE, mode_o);
    @(posedge clk_i);
    supply <= 1'b1;
    brown <= 1'b1;
    for (k = 0; k < 8 && sys_reset_o !== 1'b1; k++) step(1);
    if (sys_reset_o !== 1'b1) give_up("brown_reset");
    chk("cause_brown", 1, cause_o.brownout);
    @(posedge clk_i);
    brown <= 1'b0;
    step(6);
    chk("brown_end", 0, sys_reset_o);
  endtask
  task t_switch();
    int per;
    int highs;
    int rises;
    logic prev;
    clk_src_t s;
    for (int i = 1; i < 5; i++) begin
      s = clk_src_t'(i % 4);
      per = (s == SRC_MAIN) ? 4 : (s == SRC_EXT) ? 8 : (s == SRC_SLOW) ? 16 : 32;
      @(posedge clk_i);
      src_sel_i <= s;
      for (k = 0; k < 100 && cur_src_o !== s; k++) step(1);
      if (cur_src_o !== s) give_up("cur_src");
      step(40);
      highs = 0;
      rises = 0;
      prev = sel_clk_o;
      for (k = 0; k < 64; k++) begin
        step(1);
        highs += int'(sel_clk_o === 1'b1);
        rises += int'(sel_clk_o === 1'b1 && prev === 1'b0);
        prev = sel_clk_o;
      end
      chk("sel_highs", 32, highs);
      chk("sel_rises", 64 / per, rises);
    end
  endtask
  task t_div();
    int p;
    int q;
    @(posedge clk_i);
    div_en_i <= '1;
    for (int i = 0; i < `N_DIV; i++) begin
      meas(i, p);
      chk("div_period", i + 1, p);
    end
    @(posedge clk_i);
    frac_fra_i <= 5'h10;
    step(10);
    meas(`N_DIV, p);
    meas(`N_DIV, q);
    chk("frac_pair", 9, p + q);
  endtask
  task t_cal();
    @(posedge clk_i);
    cal_start_i <= 1'b1;
    @(posedge clk_i);
    cal_start_i <= 1'b0;
    // let the start edge clear the old done flag before it is polled
    #1;
    for (k = 0; k < 200 && cal_done_o !== 1'b1; k++) step(1);
    if (cal_done_o !== 1'b1) give_up("cal_done");
    chk("cal_count", 64, cal_count_o);
  endtask
  // frequent kicks keep the count away from the limit
  task t_dog();
    @(posedge clk_i);
    wdt_enable_i <= 1'b1;
    for (int i = 0; i < 30; i++) begin
      @(posedge clk_i);
      wdt_kick_i <= 1'b1;
      @(posedge clk_i);
      wdt_kick_i <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
    chk("serviced", 0, cause_o.watchdog);
    dog_fire(40, 80);
    @(posedge clk_i);
    wdt_src_watch_i <= 1'b1;
    dog_fire(90, 140);
    @(posedge clk_i);
    wdt_src_watch_i <= 1'b0;
  endtask
  task t_deep();
    @(posedge clk_i);
    deep_req_i <= 1'b1;
    @(posedge clk_i);
    deep_req_i <= 1'b0;
    step(1);
    chk("deep_mode", PM_DEEP, mode_o);
    chk("deep_power", 3'b000, power_o);
    dog_fire(40, 80);
    @(posedge clk_i);
    wake <= 1'b1;
    for (k = 0; k < 8 && mode_o !== PM_WAKE; k++) step(1);
    if (mode_o !== PM_WAKE) give_up("deep_wake");
    chk("wake_power", 3'b001, power_o);
    for (k = 0; k < 2000 && mode_o === PM_WAKE; k++) step(1);
    chk("wake_cycles", 1400, k);
    chk("run_power", 3'b111, power_o);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    for (int i = 0; i < `N_DIV; i++) div_val_i[i] = 24'(i);
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    supply <= 1'b1;
    step(1);
    t_reset();
    step(6);
    t_osc();
    t_sleep();
    t_supply();
    t_switch();
    t_div();
    t_cal();
    t_dog();
    t_deep();
    end_sim();
  end
endmodule
`default_nettype wire
